/* File: branch_shift_defines.vh */
// constants for the branch, break, call and wide shift execution block
`ifndef BRANCH_SHIFT_DEFINES_VH
`define BRANCH_SHIFT_DEFINES_VH
// operation codes presented on op_sel
`define OP_W 5
`define OP_NONE 5'h00
`define OP_BCC 5'h01
`define OP_BCS 5'h02
`define OP_BEQ 5'h03
`define OP_BNE 5'h04
`define OP_BGE 5'h05
`define OP_BGT 5'h06
`define OP_BRANCH_UNSIGNED_GT 5'h07
`define OP_BRANCH_UNSIGNED_LE 5'h08
`define OP_BMI 5'h09
`define OP_BPL 5'h0A
`define OP_BVC 5'h0B
`define OP_BVS 5'h0C
`define OP_JMP_SHORT 5'h0D
`define OP_JMP_LONG 5'h0E
`define OP_BIT_ZERO 5'h0F
`define OP_BIT_ONE 5'h10
`define OP_MEM_ZERO 5'h11
`define OP_MEM_ONE 5'h12
`define OP_CALL 5'h13
`define OP_BREAK 5'h14
`define OP_SHIFT 5'h15
// program counter steps
`define SHORT_LEN 16'h0002
`define BREAK_STEP 16'h0002
`define CALL_STEP 16'h0002
// status word bit positions
`define PS_C 0
`define PS_Z 1
`define PS_I 2
`define PS_V 6
`define PS_N 7
// break stacking: index of the last of its five bytes
`define PUSH_LAST 3'h4
// call stacking: index of the last of its two bytes
`define CALL_LAST 3'h1
// bank values after break
`define BANK_LOW 8'h00
`define BANK_HIGH 8'hFF
`endif

/* File: branch_condition.v */
// branch condition evaluator for flag and bit-test branches
`timescale 1ns/1ps
`include "branch_shift_defines.vh"
module branch_condition (
   // request
   input wire [4:0] op,
   input wire [15:0] ps,
   input wire tested_bit,
   // result
   output reg take
);
   wire c = ps[`PS_C];
   wire z = ps[`PS_Z];
   wire v = ps[`PS_V];
   wire n = ps[`PS_N];
   always @* begin
      case (op)
         `OP_BCC: take = ~c;
         `OP_BCS: take = c;
         `OP_BEQ: take = z;
         `OP_BNE: take = ~z;
         `OP_BGE: take = ~(n ^ v);
         `OP_BGT: take = ~z & ~(n ^ v);
         `OP_BRANCH_UNSIGNED_GT: take = c & ~z;
         `OP_BRANCH_UNSIGNED_LE: take = ~c | z;
         `OP_BMI: take = n;
         `OP_BPL: take = ~n;
         `OP_BVC: take = ~v;
         `OP_BVS: take = v;
         `OP_JMP_SHORT: take = 1'b1;
         `OP_JMP_LONG: take = 1'b1;
         `OP_BIT_ZERO: take = ~tested_bit;
         `OP_BIT_ONE: take = tested_bit;
         `OP_MEM_ZERO: take = ~tested_bit;
         `OP_MEM_ONE: take = tested_bit;
         default: take = 1'b0;
      endcase
   end
endmodule

/* File: wide_arith_right_shift.v */
// 32-bit arithmetic right shift with carry of the last bit out
`timescale 1ns/1ps
module wide_arith_right_shift (
   // operand
   input wire [31:0] value,
   input wire [4:0] count,
   input wire carry_in,
   // result
   output wire [31:0] result,
   output wire carry_out
);
   wire [63:0] ext = {{32{value[31]}}, value};
   wire [63:0] moved = ext >> count;
   // count zero moves nothing, so the carry keeps its old value
   wire [31:0] one_less = value >> (count - 5'h01);
   assign result = moved[31:0];
   assign carry_out = (count == 5'h00) ? carry_in : one_less[0];
endmodule

/* File: branch_and_shift_execution.v */
// execution of relative branches, break, relative call and wide shift
`timescale 1ns/1ps
`include "branch_shift_defines.vh"
module branch_and_shift_execution (
   // clock and reset
   input wire sys_clk,
   input wire reset_n,
   // instruction issue
   input wire start,
   input wire [4:0] op_sel,
   input wire [15:0] disp,
   input wire [15:0] inst_len,
   input wire [3:0] bit_index,
   input wire use_memory,
   input wire [15:0] mem_operand,
   input wire [4:0] shift_count,
   input wire [7:0] break_vector_bank_high,
   input wire [15:0] break_vector,
   // architectural state in
   input wire [15:0] pc_in,
   input wire [7:0] bank_in,
   input wire [15:0] ps_in,
   input wire [15:0] sp_in,
   input wire [15:0] acc_a,
   input wire [31:0] acc_e,
   // architectural state out
   output reg [15:0] pc_out,
   output reg [7:0] bank_out,
   output reg [15:0] ps_out,
   output reg [15:0] sp_out,
   output reg [31:0] acc_e_out,
   output reg done,
   output wire busy,
   // stack write port
   output reg stack_we,
   output reg [15:0] stack_addr,
   output reg [7:0] stack_data
);
   localparam IDLE = 3'b001;
   localparam PUSH = 3'b010;
   localparam FINISH = 3'b100;

   reg [2:0] state;
   reg [2:0] next_state;
   reg [2:0] push_idx;
   reg [15:0] pc_saved;
   reg [15:0] ps_saved;
   reg [7:0] bank_saved;
   reg call_mode;
   // operands of the long sequences are held from the issuing edge
   reg [15:0] disp_saved;
   reg [15:0] vector_saved;
   reg bank_high_saved;

   // memory bit branches always test the memory operand
   wire mem_form = (op_sel == `OP_MEM_ZERO) || (op_sel == `OP_MEM_ONE);
   wire [15:0] tested_word = (use_memory || mem_form) ? mem_operand
      : acc_a;
   wire tested_bit = tested_word[bit_index];
   wire take;

   branch_condition cond (
      .op(op_sel),
      .ps(ps_in),
      .tested_bit(tested_bit),
      .take(take)
   );

   wire [31:0] shifted;
   wire shift_carry;

   wide_arith_right_shift shifter (
      .value(acc_e),
      .count(shift_count),
      .carry_in(ps_in[`PS_C]),
      .result(shifted),
      .carry_out(shift_carry)
   );

   // short form sign extends the low byte; long form uses all 16 bits
   wire [15:0] disp_short = {{8{disp[7]}}, disp[7:0]};
   // call displacement is 11 bits, giving -1024..+1023
   wire [15:0] disp_call = {{5{disp_saved[10]}}, disp_saved[10:0]};
   wire is_flag_branch = (op_sel >= `OP_BCC) && (op_sel <= `OP_BVS);
   wire is_bit_branch = (op_sel >= `OP_BIT_ZERO) && (op_sel <= `OP_MEM_ONE);
   wire [15:0] base_short = pc_in + `SHORT_LEN;
   wire [15:0] base_len = pc_in + inst_len;
   wire [16:0] long_sum = {1'b0, base_len} + {1'b0, disp};
   wire [15:0] call_ret = pc_in + `CALL_STEP;

   assign busy = (state != IDLE);

   always @* begin
      next_state = state;
      case (state)
         IDLE: begin
            if (start && ((op_sel == `OP_BREAK) || (op_sel == `OP_CALL))) begin
               next_state = PUSH;
            end
         end
         PUSH: begin
            if (call_mode ? (push_idx == `CALL_LAST)
               : (push_idx == `PUSH_LAST)) begin
               next_state = FINISH;
            end
         end
         FINISH: next_state = IDLE;
         default: next_state = IDLE;
      endcase
   end

   // byte pushed at each step of the break or call sequence
   reg [7:0] push_byte;
   always @* begin
      push_byte = 8'h00;
      if (call_mode) begin
         push_byte = (push_idx == 3'h0) ? pc_saved[15:8] : pc_saved[7:0];
      end else begin
         case (push_idx)
            3'h0: push_byte = bank_saved;
            3'h1: push_byte = pc_saved[15:8];
            3'h2: push_byte = pc_saved[7:0];
            3'h3: push_byte = ps_saved[15:8];
            default: push_byte = ps_saved[7:0];
         endcase
      end
   end

   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= IDLE;
         push_idx <= 3'h0;
         pc_saved <= 16'h0000;
         ps_saved <= 16'h0000;
         bank_saved <= 8'h00;
         call_mode <= 1'b0;
         disp_saved <= 16'h0000;
         vector_saved <= 16'h0000;
         bank_high_saved <= 1'b0;
         pc_out <= 16'h0000;
         bank_out <= 8'h00;
         ps_out <= 16'h0000;
         sp_out <= 16'h0000;
         acc_e_out <= 32'h00000000;
         done <= 1'b0;
         stack_we <= 1'b0;
         stack_addr <= 16'h0000;
         stack_data <= 8'h00;
      end else begin
         state <= next_state;
         done <= 1'b0;
         stack_we <= 1'b0;
         case (state)
            IDLE: begin
               if (start) begin
                  // flags pass through untouched unless stated otherwise
                  ps_out <= ps_in;
                  bank_out <= bank_in;
                  sp_out <= sp_in;
                  acc_e_out <= acc_e;
                  push_idx <= 3'h0;
                  // inputs may move while busy, so finish uses copies
                  disp_saved <= disp;
                  vector_saved <= break_vector;
                  bank_high_saved <= break_vector_bank_high[0];
                  if (is_flag_branch) begin
                     done <= 1'b1;
                     pc_out <= take ? base_short + disp_short : base_short;
                  end else if (op_sel == `OP_JMP_SHORT) begin
                     done <= 1'b1;
                     pc_out <= base_len + disp_short;
                  end else if (op_sel == `OP_JMP_LONG) begin
                     done <= 1'b1;
                     pc_out <= long_sum[15:0];
                     // positive offset wrap carries; negative without carry
                     // out borrows
                     if (!disp[15] && long_sum[16]) begin
                        bank_out <= bank_in + 8'h01;
                     end else if (disp[15] && !long_sum[16]) begin
                        bank_out <= bank_in - 8'h01;
                     end
                  end else if (is_bit_branch) begin
                     done <= 1'b1;
                     pc_out <= take ? base_len + disp_short : base_len;
                  end else if (op_sel == `OP_SHIFT) begin
                     done <= 1'b1;
                     pc_out <= base_len;
                     acc_e_out <= shifted;
                     ps_out[`PS_C] <= shift_carry;
                  end else if (op_sel == `OP_CALL) begin
                     call_mode <= 1'b1;
                     pc_saved <= call_ret;
                  end else if (op_sel == `OP_BREAK) begin
                     call_mode <= 1'b0;
                     pc_saved <= pc_in + `BREAK_STEP;
                     ps_saved <= ps_in;
                     bank_saved <= bank_in;
                  end else begin
                     // unknown code: report done with pc unchanged
                     done <= 1'b1;
                     pc_out <= pc_in;
                  end
               end
            end
            PUSH: begin
               stack_we <= 1'b1;
               stack_addr <= sp_out;
               stack_data <= push_byte;
               sp_out <= sp_out - 16'h0001;
               push_idx <= push_idx + 3'h1;
            end
            FINISH: begin
               done <= 1'b1;
               if (call_mode) begin
                  pc_out <= pc_saved + disp_call;
               end else begin
                  // only the interrupt disable flag moves on break
                  ps_out[`PS_I] <= 1'b1;
                  pc_out <= vector_saved;
                  bank_out <= bank_high_saved ? `BANK_HIGH
                     : `BANK_LOW;
               end
            end
            default: begin
               push_idx <= 3'h0;
            end
         endcase
      end
   end
endmodule

/* File: branch_and_shift_execution_properties.sv */
// assertions on the ports of the branch, break, call and shift block
`timescale 1ns/1ps
`include "branch_shift_defines.vh"
module branch_and_shift_execution_properties (
   // clock and reset
   input wire sys_clk,
   input wire reset_n,
   // issue
   input wire start,
   input wire [4:0] op_sel,
   input wire [15:0] disp,
   input wire [15:0] pc_in,
   input wire [15:0] ps_in,
   input wire [31:0] acc_e,
   input wire [15:0] break_vector,
   // results
   input wire [15:0] pc_out,
   input wire [15:0] ps_out,
   input wire [31:0] acc_e_out,
   input wire done,
   input wire busy,
   input wire stack_we,
   input wire [15:0] stack_addr
);
   wire go = start && !busy;
   wire is_br = op_sel >= `OP_BCC && op_sel <= `OP_BVS;
   wire software_break = go && op_sel == `OP_BREAK;
   wire [15:0] tgt = pc_in + 16'h0002 + {{8{disp[7]}}, disp[7:0]};
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   a_branch_done_next: assert property (go && is_br |=> done)
      else $error("branch result late");
   a_carry_clear_tgt: assert property (
      go && op_sel == `OP_BCC && !ps_in[`PS_C] |=> pc_out == $past(tgt))
      else $error("carry clear target");
   a_carry_set_tgt: assert property (
      go && op_sel == `OP_BCS && ps_in[`PS_C] |=> pc_out == $past(tgt))
      else $error("carry set target");
   a_branch_keeps_flags: assert property (go && is_br
      |=> ps_out == $past(ps_in)) else $error("branch changed flags");
   a_break_busy_span: assert property (software_break
      |=> busy [*6] ##1 (done && !busy)) else $error("break timing");
   a_break_push_count: assert property (software_break
      |=> !stack_we ##1 stack_we [*5] ##1 !stack_we)
      else $error("break push count");
   a_break_vector_load: assert property (software_break |-> ##7
      (pc_out == $past(break_vector, 7) && ps_out[`PS_I]))
      else $error("break vector");
   a_stack_addr_step: assert property (stack_we && $past(stack_we)
      |-> stack_addr == $past(stack_addr) - 16'h0001)
      else $error("stack address step");
   a_call_done_time: assert property (go && op_sel == `OP_CALL
      |-> ##4 done) else $error("call timing");
   a_shift_sign_kept: assert property (go && op_sel == `OP_SHIFT
      |=> acc_e_out[31] == $past(acc_e[31])) else $error("shift sign");
endmodule

/* File: test_branch_and_shift_execution.sv */
// self-checking bench for the branch, break, call and shift block
`timescale 1ns/1ps
`include "branch_shift_defines.vh"
module test_branch_and_shift_execution;
   reg sys_clk = 0, reset_n = 0, start, use_memory;
   reg [4:0] op_sel, shift_count;
   reg [15:0] disp, inst_len, mem_operand, break_vector, pc_in, ps_in;
   reg [15:0] sp_in, acc_a;
   reg [3:0] bit_index;
   reg [7:0] break_vector_bank_high, bank_in;
   reg [31:0] acc_e;
   wire [15:0] pc_out, ps_out, sp_out, stack_addr;
   wire [7:0] bank_out, stack_data;
   wire [31:0] acc_e_out;
   wire done, busy, stack_we;
   integer n_errors = 0, cmp_count = 0, cyc = 0, np, i, k;
   reg [7:0] pd [0:7];
   reg [15:0] pa [0:7];
   always #50 sys_clk = ~sys_clk;
   branch_and_shift_execution u_dut (.sys_clk(sys_clk), .reset_n(reset_n),
      .start(start), .op_sel(op_sel), .disp(disp), .inst_len(inst_len),
      .bit_index(bit_index), .use_memory(use_memory),
      .mem_operand(mem_operand), .shift_count(shift_count),
      .break_vector_bank_high(break_vector_bank_high),
      .break_vector(break_vector), .pc_in(pc_in), .bank_in(bank_in),
      .ps_in(ps_in), .sp_in(sp_in), .acc_a(acc_a), .acc_e(acc_e),
      .pc_out(pc_out), .bank_out(bank_out), .ps_out(ps_out),
      .sp_out(sp_out), .acc_e_out(acc_e_out), .done(done), .busy(busy),
      .stack_we(stack_we), .stack_addr(stack_addr),
      .stack_data(stack_data));
   task final_report;
      begin
         $display("compares %0d mismatches %0d", cmp_count, n_errors);
         if (n_errors == 0 && cmp_count > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   // the run is cut off here at 8000 cycles; the done wait itself gives up after 20
   always @(posedge sys_clk) begin
      cyc = cyc + 1;
      if (cyc == 8000) begin
         n_errors = n_errors + 1;
         final_report;
      end
   end
   task chk(input [39:0] got, input [39:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   function [15:0] sx8(input [15:0] d);
      sx8 = {{8{d[7]}}, d[7:0]};
   endfunction
   function take(input [4:0] op, input [15:0] p);
      reg c, z, v, n;
      begin
         {c, z, v, n} = {p[0], p[1], p[6], p[7]};
         case (op)
            1: take = !c; 2: take = c; 3: take = z; 4: take = !z;
            5: take = !(n ^ v); 6: take = !z && !(n ^ v);
            7: take = c && !z; 8: take = !c || z; 9: take = n;
            10: take = !n; 11: take = !v; default: take = v;
         endcase
      end
   endfunction
   // stimulus lands by NBA; results sampled 1 ns after each edge
   task issue(input [4:0] op, input [15:0] d);
      begin
         @(posedge sys_clk);
         start <= 1;
         op_sel <= op;
         disp <= d;
         shift_count <= d[4:0];
         inst_len <= 16'h0002 + ($urandom % 4);
         {pc_in, ps_in, sp_in, acc_a} <= {$urandom, $urandom};
         {acc_e, mem_operand, break_vector} <= {$urandom, $urandom, $urandom};
         {bank_in, break_vector_bank_high, bit_index, use_memory} <= $urandom;
         @(posedge sys_clk);
         start <= 0;
         // single-cycle results stand only until the next edge
         #1;
         np = 0;
         k = 0;
         while (!done && k < 20) begin
            @(posedge sys_clk);
            #1;
            k = k + 1;
            if (stack_we && np < 8) begin
               pd[np] = stack_data;
               pa[np] = stack_addr;
               np = np + 1;
            end
         end
      end
   endtask
   task verify;
      reg [15:0] p2, nx, sh, lj, cj, a;
      reg [16:0] s;
      reg [39:0] e;
      reg [31:0] q;
      reg [7:0] bk;
      reg b;
      begin
         // sums are kept at 16 bits so they wrap like the program counter
         p2 = pc_in + 16'h0002;
         nx = pc_in + inst_len;
         sh = p2 + sx8(disp);
         lj = nx + sx8(disp);
         cj = p2 + {{5{disp[10]}}, disp[10:0]};
         q = $signed(acc_e) >>> shift_count;
         b = (use_memory || op_sel >= `OP_MEM_ZERO) ? mem_operand[bit_index]
            : acc_a[bit_index];
         e = {bank_in, p2, ps_in};
         chk(done, 1);
         chk(busy, 0);
         if (op_sel == `OP_CALL) chk(np, 2);
         else if (op_sel == `OP_BREAK) chk(np, 5);
         else chk(np, 0);
         if (op_sel == `OP_CALL) e = {p2, 24'h0};
         for (k = 0; k < np; k = k + 1) begin
            a = sp_in - k[15:0];
            chk(pd[k], e[39 - 8 * k -: 8]);
            chk(pa[k], a);
         end
         if (op_sel >= `OP_BCC && op_sel <= `OP_BVS) begin
            chk(pc_out, take(op_sel, ps_in) ? sh : p2);
            chk(ps_out, ps_in);
         end else if (op_sel >= `OP_BIT_ZERO && op_sel <= `OP_MEM_ONE) begin
            if (op_sel == `OP_BIT_ZERO || op_sel == `OP_MEM_ZERO) b = !b;
            chk(pc_out, b ? lj : nx);
            chk(ps_out, ps_in);
         end else if (op_sel == `OP_JMP_SHORT) begin
            chk(pc_out, lj);
         end else if (op_sel == `OP_JMP_LONG) begin
            s = {1'b0, nx} + {1'b0, disp};
            bk = bank_in;
            if (!disp[15] && s[16]) bk = bank_in + 8'h01;
            else if (disp[15] && !s[16]) bk = bank_in - 8'h01;
            chk(pc_out, s[15:0]);
            chk(bank_out, bk);
         end else if (op_sel == `OP_CALL) begin
            a = sp_in - 16'h0002;
            chk(pc_out, cj);
            chk(sp_out, a);
         end else if (op_sel == `OP_BREAK) begin
            a = sp_in - 16'h0005;
            chk(pc_out, break_vector);
            chk(bank_out, {8{break_vector_bank_high[0]}});
            chk(ps_out, ps_in | 16'h0004);
            chk(sp_out, a);
         end else if (op_sel == `OP_SHIFT) begin
            b = (shift_count != 5'h00) ? acc_e[shift_count - 1] : ps_in[0];
            chk(acc_e_out, q);
            chk(ps_out[0], b);
         end else
            chk(pc_out, pc_in);
      end
   endtask
   initial begin
      {start, op_sel, disp, inst_len, bit_index, use_memory} = 0;
      {mem_operand, shift_count, break_vector_bank_high} = 0;
      {break_vector, pc_in, bank_in, ps_in, sp_in, acc_a, acc_e} = 0;
      void'($urandom(4));
      repeat (12) @(posedge sys_clk);
      reset_n <= 1;
      // flag branches at both displacement extremes, then random
      for (i = 0; i < 72; i = i + 1) begin
         issue(1 + i % 12, i < 12 ? 16'h0080 : i < 24 ? 16'h007F : $urandom);
         verify;
      end
      $display("test 1 done");
      // jumps, bit tests, call, break, shift and an unused code
      for (i = 0; i < 120; i = i + 1) begin
         issue(5'h0D + i % 10, i < 10 ? 16'h8000 : i < 20 ? 16'h001F : $urandom);
         verify;
      end
      $display("test 2 done");
      final_report;
   end
endmodule
bind branch_and_shift_execution branch_and_shift_execution_properties
   u_props (.sys_clk(sys_clk), .reset_n(reset_n), .start(start),
   .op_sel(op_sel), .disp(disp), .pc_in(pc_in), .ps_in(ps_in),
   .acc_e(acc_e), .break_vector(break_vector), .pc_out(pc_out),
   .ps_out(ps_out), .acc_e_out(acc_e_out), .done(done), .busy(busy),
   .stack_we(stack_we), .stack_addr(stack_addr));
